// ---- core/modem_ctl_pkg.sv ----
// Constants for the modem interrupt and cipher control bank.
// Assumes one pclk domain and an APB slave with 32-bit data.
package modem_ctl_pkg;
  localparam int ADDR_W = 8;
  // Register index; byte address is four times the index
  localparam logic [5:0] IDX_INT = 6'h00;
  localparam logic [5:0] IDX_CIPH = 6'h01;
  localparam logic [5:0] IDX_ADDR = 6'h02;
  localparam logic [5:0] IDX_CNT = 6'h03;
  localparam logic [15:0] INT_RESET = 16'h0000;
  localparam logic [7:0] CIPH_RESET = 8'h1c;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // Interrupt register fields: flags 7:0, enables 15:8
  localparam int F_CIPHER = 4;
  localparam int F_OVR = 7;
  localparam int EN_CIPHER = 12;
  localparam int EN_OVR = 15;
  // Cipher control fields
  localparam int C_START = 0;
  localparam int C_MODE = 1;
  localparam int C_OP = 2;
  localparam int C_IDLE = 4;
  localparam logic [1:0] OP_NONE = 2'b00;
  localparam logic [1:0] OP_CRC = 2'b01;
  localparam logic [1:0] OP_CIPH = 2'b10;
  localparam logic [31:0] CRC_SEED = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [1:0] LAST_WORD = 2'h3;
  localparam logic [15:0] BLK_WORDS = 16'h0004;
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_READ = 7'b0000010,
    S_CAPT = 7'b0000100,
    S_CIPH = 7'b0001000,
    S_WRITE = 7'b0010000,
    S_CRC = 7'b0100000,
    S_DONE = 7'b1000000
  } eng_state_t;
endpackage

// ---- core/crc_if.sv ----
// Carrier between the cipher sequencer and the CRC32 unit.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
`default_nettype none
interface crc_if;
  logic init;
  logic step;
  logic [15:0] data;
  logic [31:0] value;
  modport engine (output init, output step, output data, input value);
  modport unit (input init, input step, input data, output value);
endinterface
`default_nettype wire

// ---- core/crc32_unit.sv ----
// CRC32 accumulator, 16 bits per step, MSB first.
// Assumes init and step come from the sequencer on pclk.
`timescale 1ns/1ps
`default_nettype none
module crc32_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sequencer side
  crc_if.unit crc
);
  import modem_ctl_pkg::*;

  logic [31:0] crc_reg;
  logic [31:0] crc_next;

  always_comb begin
    crc_next = crc_reg;
    for (int i = 15; i >= 0; i--) begin
      if (crc_next[31] ^ crc.data[i]) begin
        crc_next = {crc_next[30:0], 1'b0} ^ CRC_POLY;
      end else begin
        crc_next = {crc_next[30:0], 1'b0};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_reg <= CRC_SEED;
    end else if (crc.init) begin
      crc_reg <= CRC_SEED;
    end else if (crc.step) begin
      crc_reg <= crc_next;
    end
  end

  assign crc.value = crc_reg;
endmodule
`default_nettype wire

// ---- core/rx_overflow_detect.sv ----
// Receive overflow detector with decoder flush pulse.
// Assumes frame status comes from same-clock receive logic.
`timescale 1ns/1ps
`default_nettype none
module rx_overflow_detect (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control and status
  input wire logic enable,
  input wire logic new_frame,
  input wire logic pending,
  // Results
  output logic detect,
  output logic flush
);
  logic frame_d_reg;
  logic hit;

  // (R10) New frame while decoder busy
  assign hit = enable && new_frame && !frame_d_reg && pending;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_d_reg <= 1'b0;
      detect <= 1'b0;
      flush <= 1'b0;
    end else begin
      frame_d_reg <= new_frame;
      detect <= hit;
      // (R1) Flush only when enabled
      flush <= hit;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ovr_flush: assert property (hit |=> flush && detect) else $error("overflow not flushed"); // (R1)
  a_no_flush_off: assert property (!enable |=> !flush) else $error("flush while disabled"); // (R2)
  a_ovr_cause: assert property (detect |-> $past(pending) && $past(enable)) else $error("spurious overflow"); // (R10)
endmodule
`default_nettype wire

// ---- core/modem_ctl_bank.sv ----
// Interrupt control and cipher control bank with cipher sequencer.
// Assumes APB3 master on pclk, async-read buffer memory, external
// 64-bit cipher core, and same-clock modem event pulses.
//
// How it works
// (R1) Enabled overflow sets its flag and flushes the decoder frame.
// (R2) Overflow detector disabled means no flush at all.
// (R3) Physical transmit enable gates the last-bit-sent interrupt.
// (R4) Buffer transmit enable gates the frame-sent interrupt.
// (R5) Physical receive enable gates the last-bit-decoded interrupt.
// (R6) Buffer receive enable gates the frame-stored interrupt.
// (R7) Cipher enable gates the operation-finished interrupt.
// (R8) Carrier sense enable gates the carrier-detected interrupt.
// (R9) Frame detect enable gates the valid-frame interrupt.
// (R10) Pending decoder data at new frame means overflow.
// (R11) Every reset loads cipher control with 1Ch.
// (R12) Cipher control bits 3:0 read/write, bit 4 read-only.
// (R13) Writing start launches cipher with current settings.
// (R14) Source data is read from the cipher address.
// (R15) With cipher on, each block is written back in place until count done.
// (R16) CRC32 of processed data is appended after the data.
// (R17) Start reseeds the CRC32 accumulator to all ones.
// (R18) Hardware clears start once the operation begins.
// (R19) Mode: zero decrypts, one encrypts; software alone changes it.
// (R20) Event flags stay set until firmware clears them.
// (R21) Cipher done flag waits for both CRC write cycles.
// (R22) Operation field: 00 off, 01 CRC only, 10 cipher only.
// (R23) Interrupt request when any flag meets its enable.
`timescale 1ns/1ps
`default_nettype none
module modem_ctl_bank (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [modem_ctl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modem events
  input wire logic phy_tx_done,
  input wire logic buffer_tx_done,
  input wire logic phy_rx_done,
  input wire logic buffer_rx_done,
  input wire logic carrier_detect,
  input wire logic frame_detect,
  // Receive status and decoder flush
  input wire logic new_frame_received,
  input wire logic decoder_data_pending,
  output logic decoder_flush,
  // Buffer memory
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  // Cipher core
  output logic cipher_go,
  output logic cipher_encrypt,
  output logic [63:0] cipher_block,
  input wire logic [63:0] cipher_result,
  input wire logic cipher_done,
  // Interrupt request
  output logic irq
);
  import modem_ctl_pkg::*;

  logic [15:0] int_reg;
  logic start_reg;
  logic [1:0] op_reg;
  logic [15:0] cipher_address_reg;
  logic [15:0] cipher_block_count_reg;
  logic cipher_done_pulse;
  logic ovr_detect;
  logic [7:0] ev_set;
  logic access;
  logic int_wr;
  logic ciph_wr;
  logic launch;
  logic crc_on;
  logic ciph_on;
  logic [31:0] rd_next;
  logic rd_ok;
  eng_state_t state;
  logic [15:0] ptr_reg;
  logic [15:0] left_reg;
  logic [1:0] idx_reg;
  logic half_reg;
  logic [15:0] cur_word;
  crc_if crc ();

  crc32_unit u_crc (
    .pclk(pclk),
    .presetn(presetn),
    .crc(crc)
  );

  rx_overflow_detect u_ovr (
    .pclk(pclk),
    .presetn(presetn),
    .enable(int_reg[EN_OVR]),
    .new_frame(new_frame_received),
    .pending(decoder_data_pending),
    .detect(ovr_detect),
    .flush(decoder_flush)
  );

  // APB: one wait state, write and read at the pready edge
  assign access = psel && penable && pready;
  assign int_wr = access && pwrite && (paddr[7:2] == IDX_INT);
  assign ciph_wr = access && pwrite && (paddr[7:2] == IDX_CIPH);

  always_comb begin
    rd_ok = 1'b1;
    case (paddr[7:2])
      IDX_INT: rd_next = {16'h0000, int_reg};
      // (R12) Bit 4 shows engine idle
      IDX_CIPH: rd_next = {27'h0000000, state == S_IDLE, op_reg, cipher_encrypt, start_reg};
      IDX_ADDR: rd_next = {16'h0000, cipher_address_reg};
      IDX_CNT: rd_next = {16'h0000, cipher_block_count_reg};
      default: begin
        rd_next = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= (psel && penable && !pready && !pwrite) ? rd_next : 32'h00000000;
      pslverr <= psel && penable && !pready && !rd_ok;
    end
  end

  // (R3) (R4) (R5) (R6) Event flag sources
  // (R8) (R9) Carrier and frame detect flags
  assign ev_set = {ovr_detect, frame_detect, carrier_detect, cipher_done_pulse,
                   buffer_rx_done, phy_rx_done, buffer_tx_done, phy_tx_done};

  // (R20) Sticky flags, hardware set wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_reg <= INT_RESET;
    end else if (int_wr) begin
      int_reg <= pwdata[15:0] | {8'h00, ev_set};
    end else begin
      int_reg[7:0] <= int_reg[7:0] | ev_set;
    end
  end

  // (R23) (R7) Request from any enabled flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_reg[7:0] & int_reg[15:8]);
    end
  end

  // (R11) (R12) Cipher control reset and software access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cipher_encrypt <= CIPH_RESET[C_MODE];
      op_reg <= CIPH_RESET[C_OP +: 2];
    end else if (ciph_wr) begin
      // (R19) Mode only written by software
      cipher_encrypt <= pwdata[C_MODE];
      op_reg <= pwdata[C_OP +: 2];
    end
  end

  // (R13) (R18) Start set by software, cleared at launch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= CIPH_RESET[C_START];
    end else if (ciph_wr) begin
      start_reg <= pwdata[C_START];
    end else if (launch) begin
      start_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cipher_address_reg <= ADDR_RESET;
      cipher_block_count_reg <= CNT_RESET;
    end else if (access && pwrite) begin
      if (paddr[7:2] == IDX_ADDR) begin
        cipher_address_reg <= pwdata[15:0];
      end
      if (paddr[7:2] == IDX_CNT) begin
        cipher_block_count_reg <= pwdata[15:0];
      end
    end
  end

  // (R22) Operation field decode; 11 runs both
  assign crc_on = op_reg[0];
  assign ciph_on = op_reg[1];
  assign launch = (state == S_IDLE) && start_reg;
  assign cur_word = cipher_block[{idx_reg, 4'h0} +: 16];

  // (R17) Reseed CRC at launch
  assign crc.init = launch;
  // (R16) CRC over processed words
  assign crc.step = (state == S_WRITE) && crc_on;
  assign crc.data = cur_word;

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      ptr_reg <= 16'h0000;
      left_reg <= 16'h0000;
      idx_reg <= 2'h0;
      half_reg <= 1'b0;
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 16'h0000;
      cipher_go <= 1'b0;
      cipher_block <= 64'h0000000000000000;
      cipher_done_pulse <= 1'b0;
    end else begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      cipher_go <= 1'b0;
      cipher_done_pulse <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start_reg) begin
            // (R14) Begin at the programmed address
            ptr_reg <= cipher_address_reg;
            left_reg <= cipher_block_count_reg;
            idx_reg <= 2'h0;
            half_reg <= 1'b0;
            if (op_reg == OP_NONE) begin
              state <= S_DONE;
            end else if (cipher_block_count_reg == 16'h0000) begin
              state <= crc_on ? S_CRC : S_DONE;
            end else begin
              state <= S_READ;
            end
          end
        end
        S_READ: begin
          mem_rd <= 1'b1;
          mem_addr <= ptr_reg + {14'h0000, idx_reg};
          state <= S_CAPT;
        end
        S_CAPT: begin
          cipher_block[{idx_reg, 4'h0} +: 16] <= mem_rdata;
          if (idx_reg == LAST_WORD) begin
            idx_reg <= 2'h0;
            cipher_go <= ciph_on;
            state <= ciph_on ? S_CIPH : S_WRITE;
          end else begin
            idx_reg <= idx_reg + 2'h1;
            state <= S_READ;
          end
        end
        S_CIPH: begin
          if (cipher_done) begin
            cipher_block <= cipher_result;
            state <= S_WRITE;
          end
        end
        S_WRITE: begin
          // (R15) Write back over the source
          mem_wr <= ciph_on;
          mem_addr <= ptr_reg + {14'h0000, idx_reg};
          mem_wdata <= cur_word;
          idx_reg <= idx_reg + 2'h1;
          if (idx_reg == LAST_WORD) begin
            ptr_reg <= ptr_reg + BLK_WORDS;
            left_reg <= left_reg - 16'h0001;
            if (left_reg != 16'h0001) begin
              state <= S_READ;
            end else begin
              state <= crc_on ? S_CRC : S_DONE;
            end
          end
        end
        S_CRC: begin
          // (R16) Append CRC high half, then low half
          mem_wr <= 1'b1;
          mem_addr <= ptr_reg + {15'h0000, half_reg};
          mem_wdata <= half_reg ? crc.value[15:0] : crc.value[31:16];
          half_reg <= 1'b1;
          if (half_reg) begin
            state <= S_DONE;
          end
        end
        S_DONE: begin
          // (R21) Done only after both CRC writes
          cipher_done_pulse <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_clear: assert property (launch && !ciph_wr |=> !start_reg) else $error("start not cleared"); // (R18)
  a_crc_seed: assert property (launch |=> crc.value == CRC_SEED) else $error("crc not reseeded"); // (R17)
  a_done_after_crc: assert property (cipher_done_pulse && crc_on |-> $past(state == S_CRC, 2)) else $error("done too early"); // (R21)
  a_mode_hold: assert property (!ciph_wr |=> $stable(cipher_encrypt)) else $error("mode changed by hardware"); // (R19)
  a_op_none: assert property (launch && op_reg == OP_NONE |=> state == S_DONE) else $error("op 00 touched memory"); // (R22)
  a_write_back: assert property (state == S_WRITE && ciph_on |=> mem_wr ##0 mem_addr == $past(ptr_reg) + {14'h0000, $past(idx_reg)}) else $error("no write back"); // (R15)
  a_read_source: assert property (launch && op_reg != OP_NONE && cipher_block_count_reg != 16'h0000 |=> ##1 mem_rd && mem_addr == $past(cipher_address_reg, 2)) else $error("wrong source"); // (R14)
  a_irq_cipher: assert property (int_reg[F_CIPHER] && int_reg[EN_CIPHER] |=> irq) else $error("cipher irq missing"); // (R7)
  a_flag_sticky: assert property (int_reg[F_OVR] && !int_wr |=> int_reg[F_OVR]) else $error("flag lost"); // (R20)
  a_event_wins: assert property (int_wr && frame_detect |=> int_reg[6]) else $error("event lost on clear"); // (R9)
  a_phy_tx_flag: assert property (phy_tx_done |=> int_reg[0]) else $error("phy tx flag not set"); // (R3)
  a_buf_tx_flag: assert property (buffer_tx_done |=> int_reg[1]) else $error("buffer tx flag not set"); // (R4)
  a_phy_rx_flag: assert property (phy_rx_done |=> int_reg[2]) else $error("phy rx flag not set"); // (R5)
  a_buf_rx_flag: assert property (buffer_rx_done |=> int_reg[3]) else $error("buffer rx flag not set"); // (R6)
  a_carrier_flag: assert property (carrier_detect |=> int_reg[5]) else $error("carrier flag not set"); // (R8)
  a_cipher_flag: assert property (cipher_done_pulse |=> int_reg[F_CIPHER]) else $error("cipher flag not set"); // (R7)
  a_irq_any: assert property ((|(int_reg[7:0] & int_reg[15:8])) |=> irq) else $error("irq missing"); // (R23)
  a_irq_quiet: assert property (!(|(int_reg[7:0] & int_reg[15:8])) |=> !irq) else $error("irq without flag"); // (R23)

  c_launch: cover property (launch ##[1:200] cipher_done_pulse);
  c_overflow: cover property (ovr_detect);
  c_crc_append: cover property (state == S_CRC ##1 state == S_CRC ##1 state == S_DONE);
  c_event_clear: cover property (int_wr && frame_detect);
  c_op_both: cover property (launch && op_reg == 2'b11);
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Testbench for the modem interrupt and cipher control bank.
// Assumes the bank answers APB with one wait state; memory and cipher core are modelled here.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import modem_ctl_pkg::*;
  localparam logic [63:0] KEY = 64'h0123456789abcdef;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nf, pend, flush, mem_rd, mem_wr;
  logic go, enc, cdone, irq, enc_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [5:0] evs;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [63:0] blk, cres;
  logic [15:0] wa[$], wd[$];
  int num_errors, checks, flushes;
  int pos[6] = '{0, 1, 2, 3, 5, 6};

  modem_ctl_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phy_tx_done(evs[0]), .buffer_tx_done(evs[1]), .phy_rx_done(evs[2]), .buffer_rx_done(evs[3]),
    .carrier_detect(evs[4]), .frame_detect(evs[5]), .new_frame_received(nf),
    .decoder_data_pending(pend), .decoder_flush(flush), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .cipher_go(go),
    .cipher_encrypt(enc), .cipher_block(blk), .cipher_result(cres), .cipher_done(cdone), .irq(irq));

  // Buffer memory read: data derived from the word address
  assign mem_rdata = {mem_addr[7:0] ^ 8'h3c, mem_addr[7:0]};

  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end

  // Cipher core model and bus monitors
  always @(posedge pclk) begin
    cdone <= go;
    if (go) begin
      cres <= blk ^ KEY;
      enc_seen <= enc;
    end
    if (mem_wr) begin
      wa.push_back(mem_addr);
      wd.push_back(mem_wdata);
    end
    if (flush)
      flushes++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic e);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      chk(0, 1, "apb no ready");
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1, a, d, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    logic e;
    apb(0, a, 0, e);
    chk(r, exp, m);
  endtask

  task automatic t_reset;
    chk({irq, flush, mem_wr, go}, 0, "outputs at reset");
    rd(8'h00, 32'h0000, "int reset");
    rd(8'h04, 32'h001c, "ctl reset");
    $display("reset test done");
  endtask

  task automatic t_ctl;
    logic e;
    wr(8'h04, 32'h0000);
    rd(8'h04, 32'h0010, "idle bit kept");
    wr(8'h04, 32'h000a);
    rd(8'h04, 32'h001a, "ctl rw bits");
    chk(enc, 1, "encrypt follows mode");
    apb(0, 8'h40, 0, e);
    chk({31'h0, e}, 1, "unmapped slverr");
    chk(r, 0, "unmapped read zero");
    $display("control test done");
  endtask

  task automatic pulse(input int i);
    evs[i] <= 1;
    @(posedge pclk);
    evs[i] <= 0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_events;
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, 32'h1 << (8 + pos[i]));
      pulse(i);
      chk(irq, 1, "enabled event irq");
      rd(8'h00, (32'h101 << pos[i]), "flag held");
      wr(8'h00, 0);
      pulse(i);
      chk(irq, 0, "masked event irq");
      rd(8'h00, (32'h1 << pos[i]), "flag masked");
      wr(8'h00, 0);
    end
    // Clear write and frame event meet at the access edge
    fork
      wr(8'h00, 32'h0000);
      begin
        repeat (2) @(posedge pclk);
        pulse(5);
      end
    join
    rd(8'h00, 32'h0040, "event wins clear");
    $display("event test done");
  endtask

  task automatic frame(input logic en);
    wr(8'h00, {16'h0, en, 15'h0});
    flushes = 0;
    pend <= 1;
    nf <= 1;
    repeat (4) @(posedge pclk);
    nf <= 0;
    pend <= 0;
    @(posedge pclk);
  endtask

  task automatic t_overflow;
    frame(1);
    chk(flushes, 1, "flush on overflow");
    chk(irq, 1, "overflow irq");
    rd(8'h00, 32'h8080, "overflow flag");
    frame(0);
    chk(flushes, 0, "no flush disabled");
    rd(8'h00, 32'h0000, "no flag disabled");
    $display("overflow test done");
  endtask

  task automatic run(input logic [7:0] ctl, input int nw);
    int n;
    wa.delete();
    wd.delete();
    wr(8'h00, 32'h1000);
    wr(8'h04, ctl);
    // Op 00 finishes two cycles after launch, so idle shows again
    rd(8'h04, {3'h0, ctl[3:2] == 2'b00, ctl[3:1], 1'b0}, "start cleared busy");
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(irq, 1, "cipher done irq");
    chk(wa.size(), nw, "write count");
  endtask

  task automatic t_cipher;
    wr(8'h08, 32'h0040);
    wr(8'h0c, 32'h0001);
    run(8'h0b, 4);
    for (int k = 0; k < 4; k++) begin
      chk(wa[k], 16'h0040 + k, "block addr");
      chk(wd[k], {8'h7c ^ 8'(k), 8'h40 + 8'(k)} ^ KEY[16*k+:16], "block data");
    end
    chk(enc_seen, 1, "encrypt at go");
    rd(8'h04, 32'h001a, "mode kept");
    run(8'h0f, 6);
    wr(8'h0c, 32'h0000);
    run(8'h05, 2);
    chk({wa[0], wa[1]}, 32'h00400041, "crc addr");
    chk({wd[0], wd[1]}, CRC_SEED, "crc seed");
    run(8'h01, 0);
    $display("cipher test done");
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    end_sim();
  end

  initial begin
    presetn = 0;
    {psel, penable, pwrite, nf, pend} = 0;
    {paddr, pwdata, evs} = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset();
    t_ctl();
    t_events();
    t_overflow();
    t_cipher();
    end_sim();
  end
endmodule
`default_nettype wire
